/* logic/rtci2_slave.sv */
`timescale 1ns/1ps
// Overview of operation
// - Bytes of eight bits, ninth bit acknowledges
// - Acknowledge holds data low while clock high
// - Release data after master's final not-acknowledge
// - Stop or repeated start ends a transfer
// - Start begins transfer, stop ends it
// - First byte: address 1101000 plus direction
// - Matching address gets an acknowledge
// - Write: next byte loads register pointer
// - Data bytes acknowledged, stored, pointer advanced
// - Direction one reads from the pointer
// - Read without pointer write uses old pointer
// - Slave keeps sending until not-acknowledge
// - Start and stop detected anywhere
// - Data changes only while clock low
module rtci2_slave (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic SCL,
   input wire logic SDA,
   output logic SDA_LVL,
   output logic SDA_OE,
   output logic [7:0] REG_PTR,
   output rtci2_pkg::rtci2_wr_t WR_REQ,
   output logic WR_STB,
   input wire logic [7:0] RD_DATA,
   output logic RD_STB,
   output logic BUSY
);
   import rtci2_pkg::*;

   logic scl_s1_ff, scl_s2_ff, scl_d_ff;
   logic sda_s1_ff, sda_s2_ff, sda_d_ff;
   rtci2_state_t state_ff;
   logic [3:0] cnt_ff;
   logic [7:0] rx_ff;
   logic [7:0] tx_ff;
   logic [7:0] ptr_ff;
   logic nack_ff;
   logic sda_oe_ff;
   logic sda_o_ff;
   rtci2_wr_t wr_req_ff;
   logic wr_stb_ff;
   logic rd_stb_ff;
   logic scl_rise, scl_fall, start_det, stop_det, byte_end, addr_hit;

   // Two-stage synchronisers plus one delay stage for edge finding
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         scl_s1_ff <= LINE_IDLE;
         scl_s2_ff <= LINE_IDLE;
         scl_d_ff <= LINE_IDLE;
         sda_s1_ff <= LINE_IDLE;
         sda_s2_ff <= LINE_IDLE;
         sda_d_ff <= LINE_IDLE;
      end else begin
         scl_s1_ff <= SCL;
         scl_s2_ff <= scl_s1_ff;
         scl_d_ff <= scl_s2_ff;
         sda_s1_ff <= SDA;
         sda_s2_ff <= sda_s1_ff;
         sda_d_ff <= sda_s2_ff;
      end
   end

   assign scl_rise = scl_s2_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s2_ff & scl_d_ff;
   // Data moving while clock stays high is a control condition
   assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
   assign stop_det = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
   assign byte_end = scl_fall & (cnt_ff == BYTE_BITS);
   assign addr_hit = (rx_ff[ADDR_MSB:ADDR_LSB] == SLAVE_ADDR);

   // Transfer sequencing
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state_ff <= ST_IDLE;
      end else if (start_det) begin
         state_ff <= ST_ADDR;
      end else if (stop_det) begin
         state_ff <= ST_IDLE;
      end else if (scl_fall) begin
         case (state_ff)
            ST_ADDR: begin
               if (byte_end) begin
                  state_ff <= addr_hit ? ST_ADDR_ACK : ST_IGNORE;
               end
            end
            ST_ADDR_ACK: begin
               state_ff <= (rx_ff[DIR_BIT] == DIR_READ) ? ST_RDATA : ST_WORD;
            end
            ST_WORD: begin
               if (byte_end) begin
                  state_ff <= ST_WORD_ACK;
               end
            end
            ST_WORD_ACK: begin
               state_ff <= ST_WDATA;
            end
            ST_WDATA: begin
               if (byte_end) begin
                  state_ff <= ST_WDATA_ACK;
               end
            end
            ST_WDATA_ACK: begin
               state_ff <= ST_WDATA;
            end
            ST_RDATA: begin
               if (byte_end) begin
                  state_ff <= ST_RDATA_ACK;
               end
            end
            ST_RDATA_ACK: begin
               state_ff <= nack_ff ? ST_IGNORE : ST_RDATA;
            end
            default: begin
               state_ff <= state_ff;
            end
         endcase
      end
   end

   // Bit counter: counts sampled clock pulses within a byte
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         cnt_ff <= CNT_RST;
      end else if (start_det || stop_det) begin
         cnt_ff <= CNT_RST;
      end else if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_WORD ||
                                state_ff == ST_WDATA || state_ff == ST_RDATA)) begin
         cnt_ff <= cnt_ff + 4'h1;
      end else if (byte_end) begin
         cnt_ff <= CNT_RST;
      end
   end

   // Receive shifter, sampled on rising clock
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         rx_ff <= BYTE_RST;
      end else if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_WORD || state_ff == ST_WDATA)) begin
         rx_ff <= {rx_ff[6:0], sda_s2_ff};
      end
   end

   // Master's answer after a sent byte: high means not-acknowledge
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         nack_ff <= 1'b0;
      end else if (scl_rise && state_ff == ST_RDATA_ACK) begin
         nack_ff <= sda_s2_ff;
      end
   end

   // Transmit shifter, moved on falling clock
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         tx_ff <= BYTE_RST;
      end else if (scl_fall && ((state_ff == ST_ADDR_ACK && rx_ff[DIR_BIT] == DIR_READ) ||
                                (state_ff == ST_RDATA_ACK && !nack_ff))) begin
         tx_ff <= RD_DATA;
      end else if (scl_fall && state_ff == ST_RDATA && !byte_end) begin
         tx_ff <= {tx_ff[6:0], 1'b0};
      end
   end

   // Register pointer survives between transfers
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ptr_ff <= PTR_RST;
      end else if (state_ff == ST_WORD && byte_end) begin
         ptr_ff <= rx_ff;
      end else if (state_ff == ST_WDATA && byte_end) begin
         ptr_ff <= ptr_ff + PTR_STEP;
      end else if (rd_stb_ff) begin
         ptr_ff <= ptr_ff + PTR_STEP;
      end
   end

   // Data line drive: changed after a falling clock edge, cleared on start or stop
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sda_oe_ff <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe_ff <= 1'b0;
      end else if (scl_fall) begin
         case (state_ff)
            ST_ADDR: begin
               sda_oe_ff <= byte_end & addr_hit;
            end
            ST_WORD, ST_WDATA: begin
               sda_oe_ff <= byte_end;
            end
            ST_ADDR_ACK: begin
               sda_oe_ff <= (rx_ff[DIR_BIT] == DIR_READ) ? ~RD_DATA[7] : 1'b0;
            end
            ST_RDATA: begin
               // Bit 7 of the shifter already stands on the line, so bit 6 goes next
               sda_oe_ff <= byte_end ? 1'b0 : ~tx_ff[6];
            end
            ST_RDATA_ACK: begin
               sda_oe_ff <= nack_ff ? 1'b0 : ~RD_DATA[7];
            end
            default: begin
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain: the output level is always low, the enable carries data
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sda_o_ff <= 1'b0;
      end else begin
         sda_o_ff <= 1'b0;
      end
   end

   // Register-side strobes
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         wr_stb_ff <= 1'b0;
         rd_stb_ff <= 1'b0;
         wr_req_ff <= '0;
      end else begin
         wr_stb_ff <= (state_ff == ST_WDATA) && byte_end && !start_det && !stop_det;
         rd_stb_ff <= scl_fall && !start_det && !stop_det &&
                      ((state_ff == ST_ADDR_ACK && rx_ff[DIR_BIT] == DIR_READ) ||
                       (state_ff == ST_RDATA_ACK && !nack_ff));
         if ((state_ff == ST_WDATA) && byte_end) begin
            wr_req_ff <= '{addr: ptr_ff, data: rx_ff};
         end
      end
   end

   assign SDA_LVL = sda_o_ff;
   assign SDA_OE = sda_oe_ff;
   assign REG_PTR = ptr_ff;
   assign WR_REQ = wr_req_ff;
   assign WR_STB = wr_stb_ff;
   assign RD_STB = rd_stb_ff;
   assign BUSY = (state_ff != ST_IDLE) && (state_ff != ST_IGNORE);

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   AST_START_BEGINS: assert property (start_det |=> state_ff == ST_ADDR && cnt_ff == CNT_RST && !SDA_OE)
      else $error("start did not open an address phase");
   AST_STOP_ENDS: assert property (stop_det |=> state_ff == ST_IDLE && !SDA_OE && !BUSY)
      else $error("stop did not end the transfer");
   AST_MATCH_ACK: assert property (state_ff == ST_ADDR && byte_end && addr_hit && !start_det && !stop_det
                                   |=> SDA_OE && state_ff == ST_ADDR_ACK)
      else $error("matching address not acknowledged");
   AST_MISMATCH_QUIET: assert property (state_ff == ST_IGNORE |-> !SDA_OE)
      else $error("data driven while ignoring the bus");
   AST_ACK_HELD: assert property (state_ff == ST_WDATA_ACK && scl_rise |-> SDA_OE ##1 SDA_OE)
      else $error("acknowledge not held low through clock high");
   AST_PTR_LOAD: assert property (state_ff == ST_WORD && byte_end && !start_det && !stop_det
                                  |=> REG_PTR == $past(rx_ff))
      else $error("word address not loaded into pointer");
   AST_WORD_ACK: assert property (state_ff == ST_WORD && byte_end
                                  |=> SDA_OE && state_ff == ST_WORD_ACK)
      else $error("word address not acknowledged");
   AST_DATA_ACK: assert property (state_ff == ST_WDATA && byte_end
                                  |=> SDA_OE && WR_STB && state_ff == ST_WDATA_ACK)
      else $error("data byte not acknowledged and stored");
   AST_ACK_RELEASE: assert property ((state_ff == ST_WORD_ACK || state_ff == ST_WDATA_ACK) && scl_fall
                                     |=> !SDA_OE)
      else $error("data line held past the acknowledge bit");
   AST_WRITE_STEP: assert property (WR_STB |-> WR_REQ.addr == $past(REG_PTR) &&
                                    REG_PTR == $past(REG_PTR) + PTR_STEP)
      else $error("write did not store at pointer and advance");
   AST_READ_LOAD: assert property (state_ff == ST_ADDR_ACK && scl_fall && rx_ff[DIR_BIT] == DIR_READ
                                   |=> tx_ff == $past(RD_DATA) && SDA_OE == !tx_ff[7] && RD_STB)
      else $error("first read byte not loaded from pointer");
   AST_READ_STEP: assert property (RD_STB |=> REG_PTR == $past(REG_PTR) + PTR_STEP)
      else $error("pointer did not advance after a sent byte");
   AST_NACK_RELEASE: assert property (state_ff == ST_RDATA_ACK && scl_fall && nack_ff
                                      && !start_det && !stop_det |=> !SDA_OE [*3])
      else $error("data line not released after not-acknowledge");
   AST_CHANGE_LOW: assert property ($changed(SDA_OE) && !$past(start_det) && !$past(stop_det)
                                    |-> !scl_s2_ff)
      else $error("data drive changed while clock high");
   AST_NEVER_HIGH: assert property (SDA_LVL == 1'b0)
      else $error("open-drain output drives high");
   AST_IDLE_QUIET: assert property (state_ff == ST_IDLE
                                    |-> !SDA_OE && !WR_STB && !RD_STB)
      else $error("activity outside a transfer");

   COV_WRITE: cover property (WR_STB ##[1:1000] stop_det);
   COV_READ_NACK: cover property (state_ff == ST_RDATA_ACK && scl_fall && nack_ff);
   COV_REPEAT_START: cover property (state_ff == ST_WDATA && start_det);
   COV_MISMATCH: cover property (state_ff == ST_ADDR && byte_end && !addr_hit);
   COV_READ_ACK: cover property (state_ff == ST_RDATA_ACK && scl_fall && !nack_ff);

endmodule : rtci2_slave

/* inc/rtci2_pkg.sv */
package rtci2_pkg;

   // Bus address of this slave and direction bit meaning
   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;

   // Field positions inside the address byte
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam int DIR_BIT = 0;

   // Bits per byte on the wire, data width of the register side
   localparam int DATA_W = 8;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] CNT_RST = 4'h0;

   // Reset values and pointer step
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic LINE_IDLE = 1'b1;

   // Link side timing: system clock 40 ns, bench link clock 320 ns
   localparam int CLK_PERIOD_NS = 40;
   localparam int LINK_PERIOD_NS = 320;
   localparam int LINK_CYCLES = (LINK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WORD,
      ST_WORD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK,
      ST_IGNORE
   } rtci2_state_t;

   // One register write toward the register file
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } rtci2_wr_t;

endpackage : rtci2_pkg

/* dv/rtci2_master_model.sv */
`timescale 1ns/1ps
module rtci2_master_model (
   input wire logic clk,
   input wire logic dev_pull,
   output logic scl,
   output logic sda
);
   logic pull;
   // Open drain wire with pull-up: low while either party pulls
   assign sda = !(dev_pull | pull);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask : hold
   // Works from idle and as a repeated start from a low clock
   task automatic start;
      pull = 1'b0;
      hold(2);
      scl = 1'b1;
      hold(2);
      pull = 1'b1;
      hold(2);
      scl = 1'b0;
      hold(2);
   endtask : start
   task automatic stop;
      pull = 1'b1;
      hold(2);
      scl = 1'b1;
      hold(2);
      pull = 1'b0;
      hold(4);
   endtask : stop
   // Data set mid-low, sampled mid-high, one pulse per bit
   task automatic bit_io(input logic b, output logic r);
      pull = !b;
      hold(2);
      scl = 1'b1;
      hold(2);
      r = sda;
      hold(2);
      scl = 1'b0;
      hold(2);
   endtask : bit_io
   // Eight bits then the acknowledge bit; ack_in 1 releases the line
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask : xfer
endmodule : rtci2_master_model

/* dv/rtci2_slave_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module rtci2_slave_tb;
   import rtci2_pkg::*;
   logic clk, rst_n, sda_o, sda_oe, wr_stb, rd_stb, busy, a;
   wire scl, sda;
   logic [7:0] reg_ptr, rd_data, q, p;
   logic [7:0] mem [256];
   rtci2_wr_t wr_req, exp_wr;
   rtci2_wr_t expq [$];
   int failures = 0;
   int compares = 0;
   int rd_cnt = 0;
   rtci2_slave DUT (.CLK_SYS(clk), .RST_N(rst_n), .SCL(scl), .SDA(sda), .SDA_LVL(sda_o), .SDA_OE(sda_oe),
      .REG_PTR(reg_ptr), .WR_REQ(wr_req), .WR_STB(wr_stb), .RD_DATA(rd_data), .RD_STB(rd_stb), .BUSY(busy));
   rtci2_master_model m (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
   assign rd_data = mem[reg_ptr];
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rst_n && rd_stb) begin
         rd_cnt <= rd_cnt + 1;
      end
      if (rst_n && wr_stb) begin
         mem[wr_req.addr] <= wr_req.data;
         if (expq.size() == 0) begin
            `CHK(wr_stb, 1'b0)
         end else begin
            exp_wr = expq.pop_front();
            `CHK(wr_req, exp_wr)
         end
      end
   end
   task automatic end_of_test;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic do_write(input logic [7:0] ptr, input int n);
      logic [7:0] d;
      m.start();
      m.xfer({SLAVE_ADDR, DIR_WRITE}, 1'b1, q, a);
      `CHK(a, 1'b0)
      `CHK(busy, 1'b1)
      m.xfer(ptr, 1'b1, q, a);
      `CHK(a, 1'b0)
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         expq.push_back('{addr: 8'(ptr + i), data: d});
         m.xfer(d, 1'b1, q, a);
         `CHK(a, 1'b0)
      end
      `CHK(reg_ptr, 8'(ptr + n))
   endtask : do_write
   task automatic do_read(input logic [7:0] ptr, input int n);
      int c0;
      c0 = rd_cnt;
      m.start();
      m.xfer({SLAVE_ADDR, DIR_READ}, 1'b1, q, a);
      `CHK(a, 1'b0)
      for (int i = 0; i < n; i++) begin
         m.xfer(8'hff, i == n - 1, q, a);
         `CHK(q, mem[8'(ptr + i)])
      end
      `CHK(a, 1'b1)
      `CHK(sda_oe, 1'b0)
      `CHK(sda_o, 1'b0)
      `CHK(rd_cnt - c0, n)
   endtask : do_read
   initial begin
      rst_n = 1'b0;
      void'($urandom(24));
      foreach (mem[i]) mem[i] = 8'($urandom);
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      m.hold(4);
      p = 8'($urandom);
      do_write(p, 3);
      m.stop();
      `CHK(busy, 1'b0)
      $display("test write burst done");
      p = 8'($urandom);
      do_write(p, 0);
      do_read(p, 3);
      m.stop();
      `CHK(reg_ptr, 8'(p + 3))
      $display("test pointer then read done");
      p = reg_ptr;
      do_read(p, 1);
      m.stop();
      $display("test read from old pointer done");
      m.start();
      m.xfer({7'h69, DIR_WRITE}, 1'b1, q, a);
      `CHK(a, 1'b1)
      m.xfer(8'h00, 1'b1, q, a);
      `CHK(a, 1'b1)
      `CHK(busy, 1'b0)
      m.stop();
      $display("test foreign address done");
      m.start();
      m.xfer({SLAVE_ADDR, DIR_WRITE}, 1'b1, q, a);
      for (int i = 0; i < 4; i++) m.bit_io(1'b0, a);
      m.stop();
      `CHK(busy, 1'b0)
      `CHK(reg_ptr, p + 8'h01)
      `CHK(expq.size(), 0)
      $display("test cut byte done");
      end_of_test();
   end
   initial begin
      #(40 * 20000);
      failures++;
      end_of_test();
   end
endmodule : rtci2_slave_tb
